// [common/afe_seq_regs.svh]
// timing counts, field positions and codes for the input multiplexer sequencer
`ifndef AFE_SEQ_REGS_SVH
`define AFE_SEQ_REGS_SVH
`define CONV_CYC_SHORT 2'h2
`define CONV_CYC_LONG 2'h3
`define RESULT_SHIFT 9
`define SPF_MIN 3'h2
`define SPF_MAX 3'h4
`define CHOP_POSITIVE 2'h0
`define CHOP_REVERSE 2'h1
`define FIFO_DEPTH 16
`endif

// [common/afe_seq_pkg.sv]
// types shared by the sequencer and its result buffer
`default_nettype none
package afe_seq_pkg;
  // codes equal the engine memory word of each input
  typedef enum logic [2:0] {
    MUX_IA = 3'h0,
    MUX_VA = 3'h1,
    MUX_IB = 3'h2,
    MUX_VB = 3'h3,
    MUX_TEMP = 3'h6,
    MUX_VBAT = 3'h7
  } mux_input_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_SYNC = 2'h2
  } seq_state_e;
  typedef struct packed {
    logic [6:0] addr;
    logic [31:0] data;
  } result_word_s;
  typedef struct packed {
    seq_state_e state;
    logic [1:0] idx;
    logic [1:0] cnt;
    mux_input_e mux;
    logic flen;
    logic alt;
    logic pend;
    logic req;
    logic chop;
    logic start;
    logic batt;
  } seq_reg_s;
endpackage
`default_nettype wire

// [src/result_fifo.sv]
// first-in first-out buffer for converter results
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
  } fifo_reg_s;
  fifo_reg_s q;
  fifo_reg_s d;
  logic push;
  logic pop;
  // honest flags straight from the fill count
  assign in_ready_out = (q.fill != DEPTH[AW:0]);
  assign out_valid_out = (q.fill != '0);
  assign out_data_out = q.mem[q.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    if (push && !pop) begin
      d.fill = q.fill + (AW+1)'(1);
    end else if (pop && !push) begin
      d.fill = q.fill - (AW+1)'(1);
    end
  end
  // state register, frozen while clock enable is low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule // result_fifo
`default_nettype wire

// [src/afe_mux_sequencer.sv]
// input multiplexer, conversion and chopper sequencer on the slow clock
`timescale 1ns/1ps
`default_nettype none
`include "afe_seq_regs.svh"
module afe_mux_sequencer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [2:0] states_per_frame_in,
  input wire logic alternate_frame_request_in,
  input wire logic battery_measure_enable_in,
  input wire logic system_power_ok_in,
  input wire logic filter_length_select_in,
  input wire logic [1:0] chopper_control_in,
  input wire logic last_frame_of_period_in,
  input wire logic [21:0] adc_data_in,
  output afe_seq_pkg::mux_input_e mux_select_out,
  output logic conv_start_out,
  output logic filter_length_out,
  output logic battery_monitor_on_out,
  output logic chopper_polarity_out,
  output logic frame_sync_out,
  output logic alt_frame_active_out,
  output logic [1:0] state_index_out,
  output logic result_valid_out,
  input wire logic result_ready_in,
  output afe_seq_pkg::result_word_s result_out
);
  import afe_seq_pkg::*;

  logic rst_meta_q;
  logic rst_q;
  seq_reg_s q;
  seq_reg_s d;
  logic [1:0] last_idx;
  logic [1:0] conv_cnt;
  logic last_state;
  logic req_rise;
  logic push;
  logic fifo_ready;
  result_word_s wr_word;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // input list lookup; same list for every meter equation
  function automatic mux_input_e list_entry(input logic alt, input logic [1:0] idx);
    mux_input_e sel;
    case (idx)
      2'h0: sel = alt ? MUX_TEMP : MUX_IA;
      2'h1: sel = MUX_VA;
      2'h2: sel = alt ? MUX_VBAT : MUX_IB;
      default: sel = MUX_VB;
    endcase
    return sel;
  endfunction

  // reserved frame lengths are clamped so the list never overruns
  always_comb begin
    if (states_per_frame_in < `SPF_MIN) begin
      last_idx = 2'(`SPF_MIN - 3'h1);
    end else if (states_per_frame_in > `SPF_MAX) begin
      last_idx = 2'(`SPF_MAX - 3'h1);
    end else begin
      last_idx = 2'(states_per_frame_in - 3'h1);
    end
  end

  // conversion length tracks the filter length select
  assign conv_cnt = filter_length_select_in ? (`CONV_CYC_LONG - 2'h1) : (`CONV_CYC_SHORT - 2'h1);
  // a frame shortened mid-way ends at once instead of wrapping the index
  assign last_state = (q.idx >= last_idx);
  // registered copy resets low like the idle request, so no false edge after reset
  assign req_rise = alternate_frame_request_in && !q.req;
  // a result is written only when the buffer can take it
  assign push = (q.state == ST_CONV) && (q.cnt == 2'h0) && fifo_ready;

  // result is LSB justified then moved up by the fixed shift
  always_comb begin
    wr_word.addr = {4'h0, q.mux};
    if (q.flen) begin
      wr_word.data = {1'b0, adc_data_in, {`RESULT_SHIFT{1'b0}}};
    end else begin
      wr_word.data = {2'h0, adc_data_in[20:0], {`RESULT_SHIFT{1'b0}}};
    end
  end

  // sequencer next state
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.req = alternate_frame_request_in;
    // power loss overrides the stored enable
    d.batt = battery_measure_enable_in && system_power_ok_in;
    case (q.state)
      ST_IDLE, ST_SYNC: begin
        // frame boundary: every frame starts at entry 0
        d.state = ST_CONV;
        d.idx = 2'h0;
        d.alt = q.pend;
        d.pend = 1'b0;
        d.mux = list_entry(q.pend, 2'h0);
        d.cnt = conv_cnt;
        d.flen = filter_length_select_in;
        d.start = 1'b1;
      end
      ST_CONV: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else if (fifo_ready) begin
          if (last_state) begin
            // inserted cycle; polarity changes as it begins
            d.state = ST_SYNC;
            case (chopper_control_in)
              `CHOP_POSITIVE: d.chop = 1'b0;
              `CHOP_REVERSE: d.chop = 1'b1;
              default: d.chop = last_frame_of_period_in ? q.chop : !q.chop;
            endcase
          end else begin
            d.idx = q.idx + 2'h1;
            d.mux = list_entry(q.alt, q.idx + 2'h1);
            d.cnt = conv_cnt;
            d.flen = filter_length_select_in;
            d.start = 1'b1;
          end
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // a new edge wins over the clear at the frame boundary
    if (req_rise) begin
      d.pend = 1'b1;
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // stalling on a full buffer stretches the conversion; converter must hold data
  result_fifo #(
    .WIDTH($bits(result_word_s)),
    .DEPTH(`FIFO_DEPTH)
  ) result_fifo_i (
    .clk_in(clk_in),
    .rst_n_in(rst_q),
    .ce_in(ce_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(wr_word),
    .out_valid_out(result_valid_out),
    .out_ready_in(result_ready_in),
    .out_data_out(result_out)
  );

  // outputs straight from the state register
  assign mux_select_out = q.mux;
  assign conv_start_out = q.start;
  assign filter_length_out = q.flen;
  assign battery_monitor_on_out = q.batt;
  assign chopper_polarity_out = q.chop;
  assign frame_sync_out = (q.state == ST_SYNC);
  assign alt_frame_active_out = q.alt;
  assign state_index_out = q.idx;

  // checks other than AST_CE_FREEZE are suspended while the clock enable holds state
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_q || !ce_in);

  sequence s_long_conv;
    conv_start_out && filter_length_out ##1 (q.cnt == 2'h1) ##1 (q.cnt == 2'h0);
  endsequence

  sequence s_short_conv;
    conv_start_out && !filter_length_out ##1 (q.cnt == 2'h0);
  endsequence

  sequence s_frame_end;
    push && last_state ##1 frame_sync_out;
  endsequence

  sequence s_stall;
    (q.state == ST_CONV) && (q.cnt == 2'h0) && !fifo_ready;
  endsequence

  AST_REG_STATE0: assert property (
    conv_start_out && !alt_frame_active_out && state_index_out == 2'h0 |-> mux_select_out == MUX_IA)
    else $error("regular state 0 not phase A current");

  AST_REG_STATE2: assert property (
    conv_start_out && !alt_frame_active_out && state_index_out == 2'h2 |-> mux_select_out == MUX_IB)
    else $error("regular state 2 not phase B current");

  AST_ALT_STATE0: assert property (
    conv_start_out && alt_frame_active_out && state_index_out == 2'h0 |-> mux_select_out == MUX_TEMP)
    else $error("alternate state 0 not thermal sensor");

  AST_ALT_STATE2: assert property (
    conv_start_out && alt_frame_active_out && state_index_out == 2'h2 |-> mux_select_out == MUX_VBAT)
    else $error("alternate state 2 not battery");

  AST_VOLT_KEPT: assert property (
    conv_start_out && state_index_out == 2'h1 |-> mux_select_out == MUX_VA)
    else $error("state 1 lost phase A voltage");

  AST_BATT_GATE: assert property (
    battery_monitor_on_out |-> $past(battery_measure_enable_in) && $past(system_power_ok_in))
    else $error("battery path on without enable and power");

  AST_NO_POWER: assert property (
    !system_power_ok_in |=> !battery_monitor_on_out)
    else $error("battery path on while power absent");

  AST_IDX_BOUND: assert property (
    state_index_out <= last_idx || frame_sync_out || conv_start_out)
    else $error("state index past frame length");

  AST_FRAME_START: assert property (
    frame_sync_out |=> conv_start_out && state_index_out == 2'h0)
    else $error("frame did not start at entry 0");

  AST_NEXT_ENTRY: assert property (
    push && !last_state |=> conv_start_out && state_index_out == $past(state_index_out) + 2'h1)
    else $error("frame skipped a list entry");

  AST_REQ_PENDING: assert property (
    $rose(alternate_frame_request_in) |=> q.pend || alt_frame_active_out)
    else $error("alternate request edge lost");

  AST_ALT_ONCE: assert property (
    frame_sync_out && !q.pend |=> !alt_frame_active_out)
    else $error("alternate frame repeated without request");

  AST_PEND_CLEAR: assert property (
    frame_sync_out && q.pend && !req_rise |=> alt_frame_active_out && !q.pend)
    else $error("pending flag not consumed at frame start");

  AST_LONG_CONV: assert property (
    conv_start_out && filter_length_out |-> s_long_conv)
    else $error("long conversion not three cycles");

  AST_SHORT_CONV: assert property (
    conv_start_out && !filter_length_out |-> s_short_conv)
    else $error("short conversion not two cycles");

  AST_RESULT_SHIFT: assert property (
    push |-> wr_word.data[8:0] == 9'h0 && wr_word.addr == {4'h0, mux_select_out})
    else $error("result word misplaced");

  AST_BATT_WORD: assert property (
    push && mux_select_out == MUX_VBAT |-> wr_word.addr == 7'h07)
    else $error("battery result not at word 07");

  AST_SYNC_ONE: assert property (
    push && last_state |-> s_frame_end ##1 !frame_sync_out)
    else $error("inserted cycle not exactly one");

  AST_CHOP_FIXED: assert property (
    frame_sync_out && $past(chopper_control_in) == `CHOP_REVERSE |-> chopper_polarity_out)
    else $error("reverse mode polarity not high");

  AST_CHOP_POS: assert property (
    frame_sync_out && $past(chopper_control_in) == `CHOP_POSITIVE |-> !chopper_polarity_out)
    else $error("positive mode polarity not low");

  AST_CHOP_HOLD: assert property (
    $rose(frame_sync_out) && $past(chopper_control_in[1]) && $past(last_frame_of_period_in)
      |-> chopper_polarity_out == $past(chopper_polarity_out))
    else $error("chop toggled after period end");

  AST_CHOP_STEADY: assert property (
    !frame_sync_out |-> $stable(chopper_polarity_out))
    else $error("polarity moved outside inserted cycle");

  // multiplexer list, frame length, frame type and battery path checks
  AST_STATE3_VB: assert property (
    conv_start_out && state_index_out == 2'h3 |-> mux_select_out == MUX_VB)
    else $error("state 3 not phase B voltage");

  AST_FRAME_LEN: assert property (
    frame_sync_out && $past(states_per_frame_in) inside {3'h2, 3'h3, 3'h4}
      |-> $past(state_index_out) >= 2'($past(states_per_frame_in) - 3'h1))
    else $error("frame ended before its programmed length");

  AST_ALT_FRAME_ONLY: assert property (
    $changed(alt_frame_active_out) |-> $past(frame_sync_out))
    else $error("frame type changed inside a frame");

  AST_BATT_ON: assert property (
    $past(rst_q) && $past(ce_in) && $past(battery_measure_enable_in) && $past(system_power_ok_in)
      |-> battery_monitor_on_out)
    else $error("battery path off although enabled with power");

  // conversion timing, short result width, inserted cycle and chop toggle checks
  AST_START_PULSE: assert property (
    conv_start_out |=> !conv_start_out)
    else $error("conversion start longer than one cycle");

  AST_FLEN_STEADY: assert property (
    !conv_start_out |-> $stable(filter_length_out) && $stable(mux_select_out))
    else $error("input or filter length moved inside a conversion");

  AST_FLEN_DATA: assert property (
    push && !filter_length_out |-> !wr_word.data[30])
    else $error("short filter result wider than 21 bits");

  AST_SYNC_AFTER_PUSH: assert property (
    $rose(frame_sync_out) |-> $past(push))
    else $error("inserted cycle without a finished last state");

  AST_CHOP_TOGGLE: assert property (
    $rose(frame_sync_out) && $past(chopper_control_in[1]) && !$past(last_frame_of_period_in)
      |-> chopper_polarity_out != $past(chopper_polarity_out))
    else $error("chop mode did not toggle at frame end");

  // buffer stall and clock enable checks
  AST_STALL_HOLD: assert property (
    s_stall |=> !conv_start_out && !frame_sync_out && $stable(mux_select_out))
    else $error("stalled conversion moved on");

  AST_RESULT_VALID: assert property (
    push |=> result_valid_out)
    else $error("written result not offered");

  AST_CE_FREEZE: assert property (
    @(posedge clk_in) disable iff (!rst_q) !ce_in |=> $stable(q))
    else $error("state moved while clock enable low");
endmodule // afe_mux_sequencer
`default_nettype wire

// [test/adc_model.sv]
// behavioural converter model facing the sequencer's multiplexer side
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic conv_start_in,
  input wire logic frame_sync_in,
  input wire logic filter_length_in,
  input wire afe_seq_pkg::mux_input_e mux_select_in,
  output logic [21:0] adc_data_out
);
  import afe_seq_pkg::*;
  // sample codes its input in the low bits; top bit set only by the long filter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_data_out <= 22'h000000;
    end else if (conv_start_in) begin
      adc_data_out <= {filter_length_in, 13'h0A5C, 5'h00, mux_select_in};
    end else if (frame_sync_in) begin
      // idle between frames: inverted so a stale sample never passes
      adc_data_out <= ~adc_data_out;
    end
  end
endmodule // adc_model
`default_nettype wire

// [test/tb_afe_mux_sequencer.sv]
// self-checking bench for the multiplexer sequencer with a converter model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module tb_afe_mux_sequencer;
  import afe_seq_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce = 1'b1;
  logic [2:0] spf = 3'h4;
  logic req = 1'b0;
  logic battery_measure_enable = 1'b0;
  logic pwr = 1'b1;
  logic flen = 1'b1;
  logic [1:0] chop = 2'h0;
  logic last = 1'b0;
  logic ready = 1'b1;
  logic p;
  logic [21:0] adc;
  mux_input_e mux;
  logic conv_start, flen_o, batt_on, pol, fsync, alt, valid;
  logic [1:0] idx;
  result_word_s res;
  result_word_s q[$];
  int g[$];
  int gap_cnt = 0;
  int fail_count = 0;
  int compares = 0;

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  afe_mux_sequencer afe_mux_sequencer_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .states_per_frame_in(spf), .alternate_frame_request_in(req), .battery_measure_enable_in(battery_measure_enable),
    .system_power_ok_in(pwr), .filter_length_select_in(flen), .chopper_control_in(chop),
    .last_frame_of_period_in(last), .adc_data_in(adc), .mux_select_out(mux),
    .conv_start_out(conv_start), .filter_length_out(flen_o), .battery_monitor_on_out(batt_on),
    .chopper_polarity_out(pol), .frame_sync_out(fsync), .alt_frame_active_out(alt),
    .state_index_out(idx), .result_valid_out(valid), .result_ready_in(ready), .result_out(res));

  adc_model adc_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .conv_start_in(conv_start),
    .frame_sync_in(fsync), .filter_length_in(flen_o), .mux_select_in(mux), .adc_data_out(adc));

  // collect taken words and the spacing of conversion starts
  always @(posedge clk_in) begin
    gap_cnt++;
    if (valid === 1'b1 && ready === 1'b1) begin
      q.push_back(res);
    end
    if (conv_start === 1'b1) begin
      g.push_back(gap_cnt);
      gap_cnt = 0;
    end
  end

  // expected engine word: coded sample, shifted left by nine
  function automatic logic [31:0] exp_data(input logic [2:0] a, input logic f);
    return {10'h000, f, 13'h0A5C, 5'h00, a} << 9;
  endfunction

  task stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // returns in the first cycle of the frame after the next sync
  task wait_sync;
    int i;
    i = 0;
    @(negedge clk_in);
    while (fsync !== 1'b1 && i < 200) begin
      @(negedge clk_in);
      i++;
    end
    `CHK("frame sync seen", 1'b1, fsync)
    @(negedge clk_in);
    `CHK("sync width", 1'b0, fsync)
    `CHK("first index", 2'h0, idx)
    `CHK("frame start", 1'b1, conv_start)
  endtask

  // one whole frame: count, inputs in order, data, conversion spacing
  task check_frame(input int n, input int nc, input logic [11:0] a, input logic alt_exp);
    wait_sync();
    q.delete();
    g.delete();
    `CHK("alt active", alt_exp, alt)
    `CHK("first input", a[2:0], mux)
    `CHK("filter length", flen, flen_o)
    wait_sync();
    `CHK("words", n, q.size())
    for (int i = 0; i < n && i < q.size(); i++) begin
      `CHK("addr", a[3*i +: 3], q[i].addr[2:0])
      `CHK("data", exp_data(a[3*i +: 3], flen), q[i].data)
    end
    `CHK("starts", n, g.size())
    if (g.size() >= 2) begin
      `CHK("gap after sync", nc + 1, g[0])
      `CHK("conv cycles", nc, g[1])
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    // regular frames over every length and both filters
    for (int f = 0; f < 2; f++) begin
      for (int n = 2; n < 5; n++) begin
        spf = 3'(n);
        flen = 1'(f);
        check_frame(n, f + 2, 12'h688, 1'b0);
      end
    end
    // a length below two acts as two
    spf = 3'h1;
    check_frame(2, 3, 12'h688, 1'b0);
    spf = 3'h4;
    $display("test regular done");
    // one-cycle request pulse gives exactly one alternate frame
    req = 1'b1;
    @(negedge clk_in);
    req = 1'b0;
    check_frame(4, 3, 12'h7CE, 1'b1);
    check_frame(4, 3, 12'h688, 1'b0);
    $display("test alternate done");
    // consumer stalls until the buffer refuses, then drains
    ready = 1'b0;
    repeat (150) @(negedge clk_in);
    `CHK("full valid", 1'b1, valid)
    g.delete();
    repeat (20) @(negedge clk_in);
    `CHK("stalled starts", 0, g.size())
    ready = 1'b1;
    repeat (60) @(negedge clk_in);
    `CHK("drained", 1'b1, q.size() >= 16)
    for (int i = 0; i < 16 && i < q.size(); i++) begin
      `CHK("fifo order", 3'(i % 4), q[i].addr[2:0])
    end
    $display("test buffer done");
    // battery path against enable and main power
    for (int k = 0; k < 4; k++) begin
      battery_measure_enable = k[1];
      pwr = k[0];
      repeat (3) @(negedge clk_in);
      `CHK("battery path", (k == 3), batt_on)
    end
    $display("test battery done");
    // clock enable low holds every register, second cycle of a frame
    wait_sync();
    @(negedge clk_in);
    ce = 1'b0;
    g.delete();
    repeat (30) @(negedge clk_in);
    `CHK("frozen index", 2'h0, idx)
    `CHK("frozen input", MUX_IA, mux)
    `CHK("frozen starts", 0, g.size())
    `CHK("frozen sync", 1'b0, fsync)
    ce = 1'b1;
    wait_sync();
    $display("test freeze done");
    // fixed polarities, then both chop codes with and without period end
    for (int c = 0; c < 2; c++) begin
      chop = 2'(c);
      wait_sync();
      wait_sync();
      `CHK("fixed polarity", 1'(c), pol)
    end
    for (int c = 2; c < 4; c++) begin
      chop = 2'(c);
      wait_sync();
      p = pol;
      wait_sync();
      `CHK("chop toggle", ~p, pol)
      last = 1'b1;
      p = pol;
      wait_sync();
      `CHK("period hold", p, pol)
      last = 1'b0;
    end
    $display("test chopper done");
    stop_test();
  end
endmodule // tb_afe_mux_sequencer
`default_nettype wire
